/* hdl/cmp_latch_pkg.sv */
// Register map, field positions and reset values of the comparator latch and reference block.
// Notes on behaviour
// [R1] Both comparator results read live at bits 7 and 6 of the auxiliary register.
// [R2] Reading the auxiliary register never refreshes the mismatch snapshots.
// [R3] Gate source bit, reset one: one routes external gate pin, zero synced comparator two.
// [R4] Sync bit, reset zero: one samples comparator two on timer clock falling edge.
// [R5] Set enable one lets a high comparator one output set the latch.
// [R6] Reset enable one lets a high comparator two output reset the latch.
// [R7] Latch inputs active high; both high forces reset state.
// [R8] Writing one to set-pulse bit sets latch, bit then self-clears; zero ignored.
// [R9] Writing one to reset-pulse bit resets latch, bit then self-clears; zero ignored.
// [R10] Lower config bit one puts latch true output on pin path one.
// [R11] Upper config bit one puts latch complement output on pin path two.
// [R12] After reset both pin paths carry the unlatched comparator outputs.
// [R13] Software clears port direction and sets output enable to see a pin.
// [R14] Latch configuration and comparator enables are independent of each other.
// [R15] Comparator control status bit always returns the real comparator result.
// [R16] Reference enable bit switches on the programmable reference, independent of comparators.
// [R17] Range bit picks level/24 or quarter plus level/32; four-bit level field.
// [R18] Enable zero, range one, level zero holds reference at ground, no divider current; the code flags ground but progDividerPower still follows the selects.
// [R19] Fixed reference on when its bit is one or the fast oscillator runs.
// [R20] Software waits a settling delay after enabling the fixed reference.
// [R21] Reference select one feeds programmable divider to that comparator, else fixed reference.
// [R22] Both reference selects zero cut divider current.
// [R23] Synced comparator two captured on timer clock falling edge after prescaler.
// [R24] Reset returns comparator control and auxiliary registers to reset values.
// [R25] Latch is a system clock flip-flop; pulse bits stand exactly one cycle.
package cmp_latch_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_AUX = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_REF = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CMP1 = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CMP2 = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_REFEN = 8'h14;
	// Auxiliary register
	localparam int AUX_MIRROR1 = 7;
	localparam int AUX_MIRROR2 = 6;
	localparam int AUX_GSS = 1;
	localparam int AUX_SYNC = 0;
	localparam logic AUX_GSS_RST = 1'h1;
	localparam logic AUX_SYNC_RST = 1'h0;
	// Latch control register
	localparam int LC_UPPER = 7;
	localparam int LC_LOWER = 6;
	localparam int LC_SETEN = 5;
	localparam int LC_RSTEN = 4;
	localparam int LC_PSET = 3;
	localparam int LC_PRST = 2;
	// Reference control register
	localparam int RC_SEL1 = 7;
	localparam int RC_SEL2 = 6;
	localparam int RC_RANGE = 5;
	localparam int RC_FIXED = 4;
	localparam int RC_LEVEL_LO = 0;
	localparam int LEVEL_W = 4;
	localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 4'h0;
	// Comparator control registers
	localparam int CC_ON = 7;
	localparam int CC_OUT = 6;
	localparam int CC_OE = 5;
	localparam logic [7:0] CC_WMASK = 8'hb7;
	// Reference enable register
	localparam int RE_PROG = 0;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

/* hdl/comparator_latch_and_reference_control.sv */
// Comparator set-reset latch, timer gate routing and reference control behind an APB slave.
`timescale 1ns/10ps
module comparator_latch_and_reference_control
	import cmp_latch_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic firstComparatorOut,
	input wire logic secondComparatorOut,
	input wire logic timerClock,
	input wire logic externalTimerGatePin,
	input wire logic fastInternalOscillator,
	output logic timerGate,
	output logic syncedSecondComparatorOut,
	output logic pinPath1,
	output logic pinPath2,
	output logic pinDrive1,
	output logic pinDrive2,
	output logic [7:0] comparator1Control,
	output logic [7:0] comparator2Control,
	output logic comparator1Mismatch,
	output logic comparator2Mismatch,
	output logic latchQ,
	output logic progReferenceEnable,
	output logic referenceRangeSelect,
	output logic [LEVEL_W-1:0] referenceLevelField,
	output logic progDividerPower,
	output logic referenceGrounded,
	output logic firstReferenceSelect,
	output logic secondReferenceSelect,
	output logic fixedReferenceEnable
);
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACCESS = 1'b1
	} bus_state_t;

	typedef struct packed {
		bus_state_t bus;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic gss;
		logic sync;
		logic [7:0] latchCtl;
		logic [7:0] refCtl;
		logic [7:0] cmp1;
		logic [7:0] cmp2;
		logic progEn;
		logic snap1;
		logic snap2;
		logic mis1;
		logic mis2;
		logic latch;
		logic timerPrev;
		logic synced;
		logic gate;
		logic pin1;
		logic pin2;
	} state_t;

	state_t s_q, s_d;
	logic commit;
	logic setIn, resetIn;
	logic [ADDR_W-1:0] a;

	always_comb begin
		s_d = s_q;
		a = paddr;
		commit = psel & penable & s_q.ready;
		s_d.ready = 1'b0;
		s_d.err = 1'b0;
		s_d.bus = BUS_IDLE;
		// Answer one cycle after setup; read data sampled at setup time
		if (psel & ~penable) begin
			s_d.bus = BUS_ACCESS;
			s_d.ready = 1'b1;
			s_d.rdata = DATA_ZERO;
			case (a)
				OFF_AUX: begin
					s_d.rdata[AUX_MIRROR1] = firstComparatorOut; // [R1]
					s_d.rdata[AUX_MIRROR2] = secondComparatorOut; // [R1]
					s_d.rdata[AUX_GSS] = s_q.gss;
					s_d.rdata[AUX_SYNC] = s_q.sync;
				end
				OFF_LATCH: s_d.rdata[7:0] = s_q.latchCtl;
				OFF_REF: s_d.rdata[7:0] = s_q.refCtl;
				OFF_CMP1: begin
					s_d.rdata[7:0] = s_q.cmp1;
					s_d.rdata[CC_OUT] = firstComparatorOut; // [R15]
				end
				OFF_CMP2: begin
					s_d.rdata[7:0] = s_q.cmp2;
					s_d.rdata[CC_OUT] = secondComparatorOut; // [R15]
				end
				OFF_REFEN: s_d.rdata[RE_PROG] = s_q.progEn;
				default: s_d.err = 1'b1;
			endcase
		end else if (s_q.bus == BUS_ACCESS && !commit) begin
			s_d.bus = BUS_ACCESS;
			s_d.ready = s_q.ready;
			s_d.err = s_q.err;
		end
		// Pulse bits stand for one cycle then clear themselves
		s_d.latchCtl[LC_PSET] = 1'b0; // [R25]
		s_d.latchCtl[LC_PRST] = 1'b0; // [R25]
		if (commit && !s_q.err && pwrite) begin
			case (a)
				OFF_AUX: begin
					s_d.gss = pwdata[AUX_GSS]; // [R3]
					s_d.sync = pwdata[AUX_SYNC]; // [R4]
				end
				OFF_LATCH: begin
					s_d.latchCtl[7:LC_RSTEN] = pwdata[7:LC_RSTEN]; // [R14]
					s_d.latchCtl[LC_PSET] = pwdata[LC_PSET]; // [R8]
					s_d.latchCtl[LC_PRST] = pwdata[LC_PRST]; // [R9]
				end
				OFF_REF: s_d.refCtl = pwdata[7:0]; // [R17]
				OFF_CMP1: s_d.cmp1 = pwdata[7:0] & CC_WMASK; // [R14]
				OFF_CMP2: s_d.cmp2 = pwdata[7:0] & CC_WMASK;
				OFF_REFEN: s_d.progEn = pwdata[RE_PROG]; // [R16]
				default: s_d.progEn = s_q.progEn;
			endcase
		end
		// Only control register reads refresh mismatch snapshots, aux reads do not
		if (commit && !pwrite && a == OFF_CMP1) begin
			s_d.snap1 = firstComparatorOut; // [R2]
		end
		if (commit && !pwrite && a == OFF_CMP2) begin
			s_d.snap2 = secondComparatorOut; // [R2]
		end
		s_d.mis1 = firstComparatorOut ^ s_d.snap1;
		s_d.mis2 = secondComparatorOut ^ s_d.snap2;
		// Latch sampled on the system clock; a glitch shorter than a cycle may be missed
		setIn = (s_q.latchCtl[LC_SETEN] & firstComparatorOut) | s_q.latchCtl[LC_PSET]; // [R5] [R8]
		resetIn = (s_q.latchCtl[LC_RSTEN] & secondComparatorOut) | s_q.latchCtl[LC_PRST]; // [R6] [R9]
		if (resetIn) begin
			s_d.latch = 1'b0; // [R7]
		end else if (setIn) begin
			s_d.latch = 1'b1; // [R25]
		end
		// Timer clock is the prescaled clock; falling edge seen against last sample
		s_d.timerPrev = timerClock;
		if (!s_q.sync) begin
			s_d.synced = secondComparatorOut; // [R4]
		end else if (s_q.timerPrev & ~timerClock) begin
			s_d.synced = secondComparatorOut; // [R23]
		end
		s_d.gate = s_d.gss ? externalTimerGatePin : s_d.synced; // [R3]
		s_d.pin1 = s_d.latchCtl[LC_LOWER] ? s_d.latch : firstComparatorOut; // [R10]
		s_d.pin2 = s_d.latchCtl[LC_UPPER] ? ~s_d.latch : secondComparatorOut; // [R11]
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.bus <= BUS_IDLE;
			s_q.gss <= AUX_GSS_RST; // [R24]
			s_q.sync <= AUX_SYNC_RST; // [R24]
			s_q.latchCtl <= REG_RST; // [R12]
			s_q.refCtl <= REG_RST;
			s_q.cmp1 <= REG_RST; // [R24]
			s_q.cmp2 <= REG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign timerGate = s_q.gate;
	assign syncedSecondComparatorOut = s_q.synced;
	assign pinPath1 = s_q.pin1;
	assign pinPath2 = s_q.pin2;
	// Port direction bits live outside; this only gates on enable and output enable
	assign pinDrive1 = s_q.cmp1[CC_ON] & s_q.cmp1[CC_OE]; // [R13]
	assign pinDrive2 = s_q.cmp2[CC_ON] & s_q.cmp2[CC_OE]; // [R13]
	assign comparator1Control = s_q.cmp1;
	assign comparator2Control = s_q.cmp2;
	assign comparator1Mismatch = s_q.mis1;
	assign comparator2Mismatch = s_q.mis2;
	assign latchQ = s_q.latch;
	assign progReferenceEnable = s_q.progEn; // [R16]
	assign referenceRangeSelect = s_q.refCtl[RC_RANGE]; // [R17]
	assign referenceLevelField = s_q.refCtl[RC_LEVEL_LO +: LEVEL_W]; // [R17]
	assign firstReferenceSelect = s_q.refCtl[RC_SEL1]; // [R21]
	assign secondReferenceSelect = s_q.refCtl[RC_SEL2]; // [R21]
	assign progDividerPower = s_q.refCtl[RC_SEL1] | s_q.refCtl[RC_SEL2]; // [R22]
	assign referenceGrounded = ~s_q.progEn & s_q.refCtl[RC_RANGE]
		& (s_q.refCtl[RC_LEVEL_LO +: LEVEL_W] == LEVEL_ZERO); // [R18]
	logic fixedEnQ;
	// Fixed reference settling is left to software
	assign fixedReferenceEnable = fixedEnQ; // [R19] [R20]
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fixedEnQ <= 1'b0;
		end else begin
			fixedEnQ <= s_d.refCtl[RC_FIXED] | fastInternalOscillator; // [R19]
		end
	end
endmodule

/* tb/cmp_far_side.sv */
// Far side: two comparators, gate pin, fast oscillator and a prescaled timer clock.
`timescale 1ns/10ps
module cmp_far_side (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] req,
	input wire logic run,
	output logic firstComparatorOut,
	output logic secondComparatorOut,
	output logic externalTimerGatePin,
	output logic fastInternalOscillator,
	output logic timerClock
);
	logic [1:0] div;
	always_ff @(posedge clk) begin
		{fastInternalOscillator, externalTimerGatePin, secondComparatorOut, firstComparatorOut} <= req;
		// Stopped timer holds its level, so no falling edge reaches the sync stage
		if (!resetn) {timerClock, div} <= 3'h0;
		else if (run) {timerClock, div} <= {timerClock, div} + 3'h1;
	end
endmodule

/* tb/cmp_latch_monitor.sv */
// Port checks of the comparator latch block.
`timescale 1ns/10ps
module cmp_latch_monitor
	import cmp_latch_pkg::*;
(
	input wire logic clk, resetn, psel, penable, pwrite, pready, latchQ,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic firstComparatorOut, secondComparatorOut, fastInternalOscillator, fixedReferenceEnable,
	input wire logic progReferenceEnable, referenceRangeSelect, progDividerPower, referenceGrounded,
	input wire logic firstReferenceSelect, secondReferenceSelect,
	input wire logic [LEVEL_W-1:0] referenceLevelField
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence latchWr;
		psel && penable && pready && pwrite && paddr == OFF_LATCH;
	endsequence
	sequence rdAt(logic [ADDR_W-1:0] a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence
	a_setup_answer: assert property (psel && !penable |=> pready ##1 !pready) else $error("answer");
	a_mirror_read: assert property (rdAt(OFF_AUX) |-> prdata[AUX_MIRROR1] == $past(firstComparatorOut)
		&& prdata[AUX_MIRROR2] == $past(secondComparatorOut) && prdata[5:2] == 4'h0) else $error("mirror");
	a_status_live: assert property (rdAt(OFF_CMP1) |-> prdata[CC_OUT] == $past(firstComparatorOut))
		else $error("status");
	// Reset dominance: the comparator reset is blocked out of this one by clearing reset enable
	a_set_pulse: assert property (latchWr ##0 (pwdata[LC_PSET] && !pwdata[LC_PRST] && !pwdata[LC_RSTEN])
		|-> ##[1:3] latchQ ##1 latchQ) else $error("set pulse");
	a_rst_pulse: assert property (latchWr ##0 pwdata[LC_PRST] |-> ##[1:3] !latchQ) else $error("reset pulse");
	a_fixed_osc: assert property (fastInternalOscillator |=> fixedReferenceEnable) else $error("fixed ref");
	a_divider_cut: assert property (progDividerPower == (firstReferenceSelect || secondReferenceSelect))
		else $error("divider");
	a_ref_ground: assert property (referenceGrounded == (!progReferenceEnable && referenceRangeSelect
		&& referenceLevelField == LEVEL_ZERO)) else $error("ground");
endmodule
bind comparator_latch_and_reference_control cmp_latch_monitor monU (.clk, .resetn, .psel, .penable, .pwrite,
	.pready, .latchQ, .paddr, .pwdata, .prdata, .firstComparatorOut, .secondComparatorOut, .fastInternalOscillator,
	.fixedReferenceEnable, .progReferenceEnable, .referenceRangeSelect, .progDividerPower, .referenceGrounded,
	.firstReferenceSelect, .secondReferenceSelect, .referenceLevelField);

/* tb/tb_top.sv */
// Self-checking bench of the comparator latch block.
`timescale 1ns/10ps
module tb_top
	import cmp_latch_pkg::*;
;
	logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, run = 1'h0, lat, err;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0001316d;
	logic [3:0] req = 4'h0;
	logic pready, pslverr, firstComparatorOut, secondComparatorOut, timerClock, externalTimerGatePin;
	logic fastInternalOscillator, timerGate, syncedSecondComparatorOut, pinPath1, pinPath2, pinDrive1, pinDrive2;
	logic comparator1Mismatch, comparator2Mismatch, latchQ, progReferenceEnable, referenceRangeSelect;
	logic progDividerPower, referenceGrounded, firstReferenceSelect, secondReferenceSelect, fixedReferenceEnable;
	logic [7:0] comparator1Control, comparator2Control;
	logic [LEVEL_W-1:0] referenceLevelField;
	int mismatches = 0, comparisons = 0, cyc = 0;
	comparator_latch_and_reference_control dut_u (.*);
	cmp_far_side farSide (.*);
	initial forever #5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [1:0] pins(input logic [7:0] cfg, input logic l, input logic [1:0] c);
		return {cfg[LC_UPPER] ? !l : c[1], cfg[LC_LOWER] ? l : c[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (mismatches == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Master holds everything until pready is seen high, one idle cycle after each transfer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			apb(1'h0, 8'(4 * i), 32'h0);
			chk(rd, (i == 0) ? 32'h2 : 32'h0);
		end
		apb(1'h0, 8'h18, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		req <= 4'h3;
		repeat (5) @(posedge clk);
		chk({pinPath2, pinPath1, latchQ}, 3'h6);
		req <= 4'h4;
		repeat (5) @(posedge clk);
		chk(timerGate, 1'h1);
		apb(1'h1, OFF_AUX, 32'h0);
		req <= 4'h2;
		repeat (5) @(posedge clk);
		chk({timerGate, syncedSecondComparatorOut}, 2'h3);
		apb(1'h1, OFF_AUX, 32'h1);
		req <= 4'h0;
		repeat (5) @(posedge clk);
		chk(syncedSecondComparatorOut, 1'h1);
		run <= 1'h1;
		repeat (20) @(posedge clk);
		chk(syncedSecondComparatorOut, 1'h0);
		req <= 4'h1;
		apb(1'h1, OFF_LATCH, 32'h20);
		repeat (3) @(posedge clk);
		chk(latchQ, 1'h1);
		req <= 4'h3;
		apb(1'h1, OFF_LATCH, 32'h30);
		repeat (3) @(posedge clk);
		chk(latchQ, 1'h0);
		apb(1'h1, OFF_LATCH, 32'h0);
		apb(1'h0, OFF_CMP1, 32'h0);
		req <= 4'h2;
		repeat (4) @(posedge clk);
		chk(comparator1Mismatch, 1'h1);
		apb(1'h0, OFF_AUX, 32'h0);
		chk({rd, comparator1Mismatch}, 33'h83);
		apb(1'h0, OFF_CMP1, 32'h0);
		chk(comparator1Mismatch, 1'h0);
		apb(1'h1, OFF_CMP1, 32'hff);
		apb(1'h0, OFF_CMP1, 32'h0);
		chk({rd, pinDrive1}, 33'h16f);
		apb(1'h1, OFF_REF, 32'h20);
		apb(1'h1, OFF_REFEN, 32'h0);
		chk({referenceGrounded, progDividerPower}, 2'h2);
		lat = 1'h0;
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			req <= seed[11:8];
			apb(1'h1, OFF_LATCH, {24'h0, seed[7:6], 2'h0, seed[3:2], 2'h0});
			apb(1'h1, OFF_REF, {24'h0, seed[23:16]});
			apb(1'h1, OFF_REFEN, {31'h0, seed[24]});
			lat = seed[2] ? 1'h0 : (seed[3] ? 1'h1 : lat);
			chk({pinPath2, pinPath1, latchQ}, {pins(seed[7:0], lat, seed[9:8]), lat});
			apb(1'h0, OFF_LATCH, 32'h0);
			chk(rd, {24'h0, seed[7:6], 6'h0});
			apb(1'h0, OFF_REF, 32'h0);
			chk(rd, {24'h0, seed[23:16]});
			chk({progReferenceEnable, fixedReferenceEnable}, {seed[24], seed[20] | seed[11]});
			chk(comparator1Control, 8'hb7);
			chk({comparator2Control, pinDrive2}, 9'h0);
			chk({firstReferenceSelect, secondReferenceSelect, referenceRangeSelect, referenceLevelField},
				{seed[23:21], seed[19:16]});
			chk(progDividerPower, seed[23] | seed[22]);
			chk(comparator2Mismatch, seed[9]);
		end
		test_done();
	end
endmodule
